/* File: src/tm2_timer.v */
// 16-bit timer/counter with capture, auto-reload and baud generation
// assumes: Avalon-MM master on clk, pins asynchronous to clk,
// serial port and interrupt controller outside consume the outputs
//
// Contract
// - the timer always counts as one 16-bit counter
// - overflow flag set on rollover from maximum, cleared only by software
// - overflow flag set by rollover only when both clock selects are zero
// - software writing one to either flag sets it, requesting interrupt
// - external flag set by any enabled trigger edge, baud mode too; software clears
// - receive select picks this timer or timer 1 overflow, modes 1, 3
// - transmit select picks this timer or timer 1 overflow, modes 1, 3
// - trigger edges ignored unless enabled; no trigger capture/reload in baud mode
// - run bit starts counting; cleared it halts counting, an enabled trigger still reloads
// - counter select counts pin falls, else clock divided by 4 or 12
// - baud mode with timer select counts clock divided by 2
// - capture mode trigger copies count into capture registers
// - auto-reload rollover sets flag and loads the reload value
// - auto-reload trigger immediately forces a reload
// - either clock select forces auto-reload, ignoring capture select
// - rollover drives the overflow pin high for exactly one cycle
// - baud mode rollover gives shift tick and reload, no flag
// - baud mode only interrupt source is the external flag
// - rate bit zero divides by 12, one by 4, ignored in baud
`timescale 1ns/1ps
`include "tm2_defs.vh"

module tm2_timer
(
   // clock and reset
   input wire clk,
   input wire rst,
   // avalon-mm slave
   input wire [9:0] address,
   input wire read,
   input wire write,
   input wire [3:0] byteenable,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   // pins
   input wire countInputPin,
   input wire externalTriggerPin,
   output reg overflowOutputPin,
   // serial port side
   input wire [1:0] serialMode,
   input wire timer1Overflow,
   output wire rxBaudTick,
   output wire txBaudTick,
   // interrupt request to controller
   output wire timerIrq
);

   localparam ST_IDLE = 2'b01;
   localparam ST_ACK = 2'b10;
   // reset image of the control register
   localparam [7:0] RST_CTRL = `TM2_RST_CTRL;

   reg [1:0] busSt_r;
   reg [1:0] busSt_nxt;
   reg ovfFlag_r;
   reg extFlag_r;
   reg rxSel_r;
   reg txSel_r;
   reg extEn_r;
   reg run_r;
   reg ctSel_r;
   reg cprlSel_r;
   reg rate_r;
   reg [15:0] cnt_r;
   reg [15:0] cnt_nxt;
   reg [15:0] rcap_r;
   reg [15:0] rcap_nxt;
   reg [3:0] pre_r;
   reg [3:0] preDiv;
   reg baudTick_r;
   reg cntSync1_r;
   reg cntSync2_r;
   reg cntPrev_r;
   reg trgSync1_r;
   reg trgSync2_r;
   reg trgPrev_r;
   reg ovfSet;
   reg extSet;

   wire acc;
   wire ack;
   wire wrEn;
   wire [7:0] idx;
   wire baudMode;
   wire reloadMode;
   wire preTick;
   wire cntFall;
   wire trgFall;
   wire trigger;
   wire inc;
   wire rollover;
   wire serialTimed;
   wire wrCtl;
   wire wrRcapL;
   wire wrRcapH;
   wire wrCntL;
   wire wrCntH;
   wire wrCkCtl;
   wire [7:0] ctrlImage;

   // register decode, one word per index
   function hit;
      input [7:0] a;
      input [7:0] i;
      begin
         hit = (a == i);
      end
   endfunction

   // last prescaler step before the tick
   function lastStep;
      input [3:0] p;
      input [3:0] d;
      begin
         lastStep = (p >= d - 4'h1);
      end
   endfunction

   assign acc = read | write;
   assign ack = (busSt_r == ST_ACK);
   assign waitrequest = acc & ~ack;
   assign idx = address[9:2];
   assign wrEn = write & ack & byteenable[0];

   // per-register write strobes
   assign wrCtl = wrEn & hit(idx, `TM2_IDX_CTRL);
   assign wrRcapL = wrEn & hit(idx, `TM2_IDX_RCAPL);
   assign wrRcapH = wrEn & hit(idx, `TM2_IDX_RCAPH);
   assign wrCntL = wrEn & hit(idx, `TM2_IDX_CNTL);
   assign wrCntH = wrEn & hit(idx, `TM2_IDX_CNTH);
   assign wrCkCtl = wrEn & hit(idx, `TM2_IDX_CKCTL);

   // bus handshake: one wait cycle, answer on the second
   always @*
   begin
      case (busSt_r)
         ST_IDLE:
            busSt_nxt = acc ? ST_ACK : ST_IDLE;
         ST_ACK:
            busSt_nxt = ST_IDLE;
         default:
            busSt_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk)
   begin
      if (rst)
         busSt_r <= ST_IDLE;
      else
         busSt_r <= busSt_nxt;
   end

   // control register as software reads it
   assign ctrlImage = {ovfFlag_r, extFlag_r, rxSel_r, txSel_r,
      extEn_r, run_r, ctSel_r, cprlSel_r};

   // read data prepared during the wait cycle
   always @(posedge clk)
   begin
      if (rst)
         readdata <= 32'h00000000;
      else if (read & ~ack)
      begin
         if (hit(idx, `TM2_IDX_CTRL))
            readdata <= {24'h000000, ctrlImage};
         else if (hit(idx, `TM2_IDX_RCAPL))
            readdata <= {24'h000000, rcap_r[7:0]};
         else if (hit(idx, `TM2_IDX_RCAPH))
            readdata <= {24'h000000, rcap_r[15:8]};
         else if (hit(idx, `TM2_IDX_CNTL))
            readdata <= {24'h000000, cnt_r[7:0]};
         else if (hit(idx, `TM2_IDX_CNTH))
            readdata <= {24'h000000, cnt_r[15:8]};
         else if (hit(idx, `TM2_IDX_CKCTL))
            readdata <= {26'h0, rate_r, 5'h00};
         else
            readdata <= 32'h00000000;
      end
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         cntSync1_r <= 1'b1;
         cntSync2_r <= 1'b1;
         cntPrev_r <= 1'b1;
         trgSync1_r <= 1'b1;
         trgSync2_r <= 1'b1;
         trgPrev_r <= 1'b1;
      end
      else
      begin
         cntSync1_r <= countInputPin;
         cntSync2_r <= cntSync1_r;
         cntPrev_r <= cntSync2_r;
         trgSync1_r <= externalTriggerPin;
         trgSync2_r <= trgSync1_r;
         trgPrev_r <= trgSync2_r;
      end
   end

   assign cntFall = cntPrev_r & ~cntSync2_r;
   assign trgFall = trgPrev_r & ~trgSync2_r;

   assign baudMode = rxSel_r | txSel_r;
   assign reloadMode = baudMode | ~cprlSel_r;

   assign trigger = extEn_r & trgFall;

   always @*
   begin
      if (baudMode)
         preDiv = `TM2_DIV_BAUD;
      else if (rate_r)
         preDiv = `TM2_DIV_FAST;
      else
         preDiv = `TM2_DIV_SLOW;
   end

   // free prescaler feeding the timer tick
   always @(posedge clk)
   begin
      if (rst)
         pre_r <= 4'h0;
      else if (lastStep(pre_r, preDiv))
         pre_r <= 4'h0;
      else
         pre_r <= pre_r + 4'h1;
   end

   assign preTick = lastStep(pre_r, preDiv);

   assign inc = run_r & (ctSel_r ? cntFall : preTick);
   assign rollover = inc & (cnt_r == `TM2_CNT_MAX);

   // count, capture and reload
   always @*
   begin
      cnt_nxt = cnt_r;
      rcap_nxt = rcap_r;
      if (inc)
         cnt_nxt = cnt_r + 16'h0001;
      if (rollover & reloadMode)
         cnt_nxt = rcap_r;
      if (trigger & ~baudMode & ~cprlSel_r)
         cnt_nxt = rcap_r;
      if (trigger & ~baudMode & cprlSel_r)
         rcap_nxt = cnt_r;
      if (wrCntL)
         cnt_nxt[7:0] = writedata[7:0];
      if (wrCntH)
         cnt_nxt[15:8] = writedata[7:0];
      if (wrRcapL)
         rcap_nxt[7:0] = writedata[7:0];
      if (wrRcapH)
         rcap_nxt[15:8] = writedata[7:0];
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r <= {`TM2_RST_BYTE, `TM2_RST_BYTE};
         rcap_r <= {`TM2_RST_BYTE, `TM2_RST_BYTE};
      end
      else
      begin
         cnt_r <= cnt_nxt;
         rcap_r <= rcap_nxt;
      end
   end

   // flag set events
   always @*
   begin
      // overflow flag only outside baud mode
      ovfSet = rollover & ~baudMode;
      // external flag, also in baud mode
      extSet = trigger;
   end

   // overflow flag; set beats a software clear
   always @(posedge clk)
   begin
      if (rst)
         ovfFlag_r <= RST_CTRL[`TM2_B_OVF];
      else if (wrCtl)
         ovfFlag_r <= writedata[`TM2_B_OVF] | ovfSet;
      else
         ovfFlag_r <= ovfFlag_r | ovfSet;
   end

   // external flag; set beats a software clear
   always @(posedge clk)
   begin
      if (rst)
         extFlag_r <= RST_CTRL[`TM2_B_EXF];
      else if (wrCtl)
         extFlag_r <= writedata[`TM2_B_EXF] | extSet;
      else
         extFlag_r <= extFlag_r | extSet;
   end

   // mode and run bits of the control register
   always @(posedge clk)
   begin
      if (rst)
      begin
         {rxSel_r, txSel_r} <= RST_CTRL[5:4];
         {extEn_r, run_r, ctSel_r, cprlSel_r} <= RST_CTRL[3:0];
      end
      else if (wrCtl)
      begin
         rxSel_r <= writedata[`TM2_B_RCLK];
         txSel_r <= writedata[`TM2_B_TRANSMIT_CLOCK_SELECT];
         extEn_r <= writedata[`TM2_B_EXEN];
         run_r <= writedata[`TM2_B_RUN];
         ctSel_r <= writedata[`TM2_B_CT];
         cprlSel_r <= writedata[`TM2_B_CPRL];
      end
   end

   // rate bit of the clock control register
   always @(posedge clk)
   begin
      if (rst)
         rate_r <= `TM2_RST_RATE;
      else if (wrCkCtl)
         rate_r <= writedata[`TM2_B_RATE];
   end

   always @(posedge clk)
   begin
      if (rst)
         overflowOutputPin <= 1'b0;
      else
         overflowOutputPin <= rollover;
   end

   always @(posedge clk)
   begin
      if (rst)
         baudTick_r <= 1'b0;
      else
         baudTick_r <= rollover & baudMode;
   end

   // serial clock source select in modes 1 and 3
   assign serialTimed = serialMode[0];
   assign rxBaudTick = serialTimed & (rxSel_r ? baudTick_r : timer1Overflow);
   assign txBaudTick = serialTimed & (txSel_r ? baudTick_r : timer1Overflow);

   // flags raise the request; enable lives in controller
   assign timerIrq = ovfFlag_r | extFlag_r;

endmodule

/* File: src/tm2_defs.vh */
// constants for the 16-bit capture/reload/baud timer
// assumes: included by the timer module only
`ifndef TM2_DEFS_VH
`define TM2_DEFS_VH

// register indices, byte address = 4 * index
`define TM2_IDX_CTRL 8'hc8
`define TM2_IDX_RCAPL 8'hca
`define TM2_IDX_RCAPH 8'hcb
`define TM2_IDX_CNTL 8'hcc
`define TM2_IDX_CNTH 8'hcd
`define TM2_IDX_CKCTL 8'h8e

// timer_two_control bit positions
`define TM2_B_OVF 7
`define TM2_B_EXF 6
`define TM2_B_RCLK 5
`define TM2_B_TRANSMIT_CLOCK_SELECT 4
`define TM2_B_EXEN 3
`define TM2_B_RUN 2
`define TM2_B_CT 1
`define TM2_B_CPRL 0

// clock_control_register rate bit
`define TM2_B_RATE 5

// reset values
`define TM2_RST_CTRL 8'h00
`define TM2_RST_BYTE 8'h00
`define TM2_RST_RATE 1'b0

// prescale divisors in clocks
`define TM2_DIV_SLOW 4'hc
`define TM2_DIV_FAST 4'h4
`define TM2_DIV_BAUD 4'h2

// count limit
`define TM2_CNT_MAX 16'hffff

`endif

/* File: tb/tm2_checker.sv */
// port assertions for the timer
// assumes: bound into tm2_timer, one clock
`timescale 1ns/1ps
module tm2_checker
(
   // clock and bus
   input wire clk,
   input wire rst,
   input wire [9:0] address,
   input wire write,
   input wire [3:0] byteenable,
   input wire [31:0] writedata,
   input wire waitrequest,
   // outputs and serial side
   input wire overflowOutputPin,
   input wire [1:0] serialMode,
   input wire timer1Overflow,
   input wire rxBaudTick,
   input wire txBaudTick,
   input wire timerIrq
);
   reg [7:0] ctrl_r;
   wire wrCtl;
   assign wrCtl = write & ~waitrequest & byteenable[0] & (address[9:2] == 8'hc8);
   // copy of software-written control
   always @(posedge clk)
      if (rst)
         ctrl_r <= 8'h00;
      else if (wrCtl)
         ctrl_r <= writedata[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_pulse; overflowOutputPin |=> !overflowOutputPin; endproperty
   a_pulse: assert property (p_pulse) else $error("pin pulse too long");
   property p_hold; timerIrq && !wrCtl |=> timerIrq; endproperty
   a_hold: assert property (p_hold) else $error("flag lost");
   property p_swSet; wrCtl && writedata[7] |=> timerIrq; endproperty
   a_swSet: assert property (p_swSet) else $error("flag not set");
   property p_gate; !serialMode[0] |-> !(rxBaudTick || txBaudTick); endproperty
   a_gate: assert property (p_gate) else $error("tick in wrong mode");
   property p_rxT1; serialMode[0] && !ctrl_r[5] |-> rxBaudTick == timer1Overflow; endproperty
   a_rxT1: assert property (p_rxT1) else $error("rx source");
   property p_txT1; serialMode[0] && !ctrl_r[4] |-> txBaudTick == timer1Overflow; endproperty
   a_txT1: assert property (p_txT1) else $error("tx source");
   property p_halt; !ctrl_r[2] |=> !overflowOutputPin; endproperty
   a_halt: assert property (p_halt) else $error("counts while off");
   property p_baud; (ctrl_r[5] || ctrl_r[4]) && !ctrl_r[3] && !wrCtl |=> !$rose(timerIrq);
   endproperty
   a_baud: assert property (p_baud) else $error("flag in baud mode");
endmodule
bind tm2_timer tm2_checker i_tm2_checker (.clk, .rst, .address, .write, .byteenable,
   .writedata, .waitrequest, .overflowOutputPin, .serialMode, .timer1Overflow,
   .rxBaudTick, .txBaudTick, .timerIrq);

/* File: tb/tm2_serial_model.sv */
// serial port stand-in: timer 1 overflow, baud tick count
// assumes: same clock as the timer
`timescale 1ns/1ps
module tm2_serial_model
(
   // clock and reset
   input wire clk,
   input wire rst,
   // timer side
   input wire rxTick,
   input wire txTick,
   output reg t1Ovf,
   output reg [7:0] rxCnt
);
   reg [1:0] div_r;
   always @(posedge clk)
   begin
      if (rst)
      begin
         div_r <= 2'h0;
         t1Ovf <= 1'b0;
         rxCnt <= 8'h00;
      end
      else
      begin
         div_r <= div_r + 2'h1;
         t1Ovf <= &div_r;
         rxCnt <= rxCnt + {7'h0, rxTick & txTick};
      end
   end
endmodule

/* File: tb/tm2_timer_tb.sv */
// self-checking bench for the timer
// assumes: tm2_timer, serial model, bound checker
`timescale 1ns/1ps
module tm2_timer_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg [9:0] address = 10'h000;
   reg read = 1'b0;
   reg write = 1'b0;
   reg [31:0] writedata = 32'h0;
   reg cntPin = 1'b1;
   reg trgPin = 1'b1;
   reg [1:0] serialMode = 2'h0;
   reg [7:0] i, d, v, t;
   wire [31:0] readdata;
   wire waitrequest, ovf, rxT, txT, irq, t1;
   wire [7:0] ticks;
   integer failures = 0, num_checks = 0, cyc = 0, n;
   tm2_timer i_tm2_timer (.clk, .rst, .address, .read, .write, .byteenable(4'h1),
      .writedata, .readdata, .waitrequest, .countInputPin(cntPin),
      .externalTriggerPin(trgPin), .overflowOutputPin(ovf), .serialMode,
      .timer1Overflow(t1), .rxBaudTick(rxT), .txBaudTick(txT), .timerIrq(irq));
   tm2_serial_model i_tm2_serial_model (.clk, .rst, .rxTick(rxT), .txTick(txT),
      .t1Ovf(t1), .rxCnt(ticks));
   initial
      forever #10 clk = ~clk;
   function [7:0] ctl(input reg [7:0] c, input reg tf, input reg ex);
      ctl = c | {tf, ex, 6'h00};
   endfunction
   task complete_run;
      begin
         if (failures == 0 && num_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input reg [7:0] got, input reg [7:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            failures = failures + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task bus(input reg w, input reg [7:0] a, input reg [7:0] wd);
      begin
         address <= {a, 2'h0};
         writedata <= {24'h0, wd};
         read <= ~w;
         write <= w;
         do
            @(posedge clk);
         while (waitrequest);
         d = readdata[7:0];
         read <= 1'b0;
         write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task pulse(input reg trg);
      begin
         trgPin <= ~trg;
         cntPin <= trg;
         repeat (3) @(posedge clk);
         trgPin <= 1'b1;
         cntPin <= 1'b1;
         repeat (6) @(posedge clk);
      end
   endtask
   task waitOvf;
      begin
         n = 0;
         do
         begin
            @(negedge clk);
            n = n + 1;
         end
         while (!ovf && n < 100);
      end
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         failures = failures + 1;
         complete_run;
      end
   end
   initial
   begin
      v = $urandom(67);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 8'hc9; i < 8'hce; i = i + 8'h1)
      begin
         v = $urandom;
         bus(1'b0, i, v);
         chk(d, 8'h00);
         bus(1'b1, i, v);
         bus(1'b0, i, v);
         chk(d, i == 8'hc9 ? 8'h00 : v);
      end
      bus(1'b1, 8'hc8, 8'h80);
      chk({7'h0, irq}, 8'h01);
      bus(1'b1, 8'hc8, 8'h40);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, ctl(8'h00, 1'b0, 1'b1));
      bus(1'b1, 8'hc8, 8'h00);
      chk({7'h0, irq}, 8'h00);
      bus(1'b1, 8'hca, 8'h00);
      bus(1'b1, 8'hcb, v);
      bus(1'b1, 8'h8e, 8'h20);
      bus(1'b1, 8'hcc, 8'hfe);
      bus(1'b1, 8'hcd, 8'hff);
      bus(1'b1, 8'hc8, 8'h04);
      waitOvf;
      chk({7'h0, ovf}, 8'h01);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, ctl(8'h04, 1'b1, 1'b0));
      bus(1'b1, 8'hc8, 8'h00);
      bus(1'b0, 8'hcd, 8'h00);
      chk(d, v);
      t = ~v;
      bus(1'b1, 8'hcc, v);
      bus(1'b1, 8'hcd, t);
      bus(1'b1, 8'hc8, 8'h09);
      pulse(1'b1);
      bus(1'b0, 8'hca, 8'h00);
      chk(d, v);
      bus(1'b0, 8'hcb, 8'h00);
      chk(d, t);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, ctl(8'h09, 1'b0, 1'b1));
      bus(1'b1, 8'hc8, 8'h08);
      bus(1'b1, 8'hcc, t);
      pulse(1'b1);
      bus(1'b0, 8'hcc, 8'h00);
      chk(d, v);
      bus(1'b1, 8'hc8, 8'h01);
      pulse(1'b1);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, 8'h01);
      for (i = 8'hca; i < 8'hce; i = i + 8'h1)
         bus(1'b1, i, 8'hff);
      serialMode <= {v[0], 1'b1};
      bus(1'b1, 8'hc8, 8'h34);
      waitOvf;
      waitOvf;
      chk(n[7:0], 8'h02);
      t = ticks;
      repeat (20) @(negedge clk);
      chk(ticks - t, 8'h0a);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, 8'h34);
      bus(1'b1, 8'hc8, 8'h00);
      bus(1'b1, 8'hcc, 8'hfe);
      bus(1'b1, 8'hcd, 8'hff);
      bus(1'b1, 8'hc8, 8'h06);
      pulse(1'b0);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, 8'h06);
      pulse(1'b0);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, ctl(8'h06, 1'b1, 1'b0));
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, 8'hc8, 8'h00);
      chk(d, 8'h00);
      pulse(1'b0);
      bus(1'b0, 8'hcc, 8'h00);
      chk(d, 8'h00);
      complete_run;
   end
endmodule
